//--- src/rsc_map.svh
`ifndef RSC_MAP_SVH
`define RSC_MAP_SVH
// Overview of operation
// - pin key 55h port pin, AAh reset input
// - other pin key resets after 2-3 ticks
// - resets restore pin key, except warm timeout
// - pin key reset flag: hardware sets, software clears
// - flag bits six to four read zero
// - qualified low supply resets, sets flag
// - short low supply is ignored
// - low supply reset after 2-3 ticks
// - low supply watch off in sleep/idle
// - 5Ah enables threshold, A5h disables it
// - bad low supply key resets, restores key
// - genuine low supply keeps select key
// - low supply flag set, software clears
// - bad select key sets error flag
// - normal timeout resets, sets timeout flag
// - sleep timeout clears pc/sp, sets timeout
// - flag effects per reset kind
// - power-on initialisation of core state
// - watchdog key error sets its flag

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define RSC_ADDR_PIN_SEL    12'h000
`define RSC_ADDR_FLAGS      12'h004
`define RSC_ADDR_LV_SEL     12'h008
`define RSC_ADDR_STATUS     12'h00c

// ------------------------------------------------------------
// keys, reset values and field positions
// ------------------------------------------------------------
`define RSC_PIN_KEY_PORT    8'h55
`define RSC_PIN_KEY_RESET   8'haa
`define RSC_LV_KEY_ON       8'h5a
`define RSC_LV_KEY_OFF      8'ha5
`define RSC_FLAG_IDLE_KEEP  7
`define RSC_FLAG_PIN        3
`define RSC_FLAG_LOWSUP     2
`define RSC_FLAG_LVERR      1
`define RSC_FLAG_WDERR      0
`define RSC_STAT_TIMEOUT    0
`define RSC_STAT_PWRDOWN    1
`define RSC_STAT_CHIPRST    2

// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RSC_CLK_PERIOD_NS       10
`define RSC_SLOW_OSC_PERIOD_NS  31250
`define RSC_SLOW_OSC_CYCLES     (`RSC_SLOW_OSC_PERIOD_NS / `RSC_CLK_PERIOD_NS)
`define RSC_DEBOUNCE_TICKS      2
`define RSC_LV_QUAL_US          100
`define RSC_LV_QUAL_CYCLES      ((`RSC_LV_QUAL_US * 1000) / `RSC_CLK_PERIOD_NS)
`define RSC_RESET_HOLD_CYCLES   8

`endif

//--- src/rsc_pkg.sv
package rsc_pkg;

  // ------------------------------------------------------------
  // sequencer states and reset causes
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN      = 3'b001,
    ST_DEBOUNCE = 3'b010,
    ST_RESET    = 3'b100
  } rsc_state_e;

  typedef enum logic [2:0] {
    CAUSE_NONE       = 3'h0,
    CAUSE_PIN_KEY    = 3'h1,
    CAUSE_LV_KEY     = 3'h2,
    CAUSE_LOW_SUPPLY = 3'h3,
    CAUSE_WDT        = 3'h4,
    CAUSE_WDT_KEY    = 3'h5,
    CAUSE_EXT_PIN    = 3'h6
  } rsc_cause_e;

  // ------------------------------------------------------------
  // complete block state
  // ------------------------------------------------------------
  typedef struct packed {
    rsc_state_e  state;
    rsc_cause_e  cause;
    logic [7:0]  pin_key;
    logic [7:0]  lv_key;
    logic        idle_keep;
    logic        pin_flag;
    logic        lowsup_flag;
    logic        lverr_flag;
    logic        wderr_flag;
    logic        timeout_flag;
    logic        power_down_flag;
    logic [11:0] tick_cnt;
    logic        slow_tick;
    logic [1:0]  deb_cnt;
    logic [15:0] qual_cnt;
    logic [3:0]  hold_cnt;
    logic        chip_reset;
    logic        pc_sp_clear;
    logic        por_init;
    logic [31:0] prdata;
  } rsc_regs_s;

endpackage

//--- src/rsc_reset_ctrl.sv
`timescale 1ns/1ps
`include "rsc_map.svh"

module rsc_reset_ctrl #(
  parameter int unsigned LV_QUAL_CYCLES = `RSC_LV_QUAL_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        shared_pin_in,
  input  wire logic        low_supply_detect,
  input  wire logic        sleep_idle_mode,
  input  wire logic        watchdog_timeout,
  input  wire logic        watchdog_key_error,
  input  wire logic        halt_enter,
  input  wire logic        watchdog_clear,
  output logic             chip_reset,
  output logic             pc_sp_clear,
  output logic             por_init,
  output logic             pin_is_reset_input,
  output logic             low_voltage_monitor_on,
  output logic             idle_system_clock_keep,
  output logic             timeout_flag,
  output logic             power_down_flag
);

  // ------------------------------------------------------------
  // constants
  // ------------------------------------------------------------
  localparam logic [11:0] TICK_LAST = 12'(`RSC_SLOW_OSC_CYCLES - 1);
  localparam logic [1:0]  DEB_LAST  = 2'(`RSC_DEBOUNCE_TICKS - 1);
  localparam logic [3:0]  HOLD_LAST = 4'(`RSC_RESET_HOLD_CYCLES - 1);
  localparam logic [15:0] QUAL_LIM  = 16'(LV_QUAL_CYCLES);
  localparam int          DEB_MAX   = 3 * `RSC_SLOW_OSC_CYCLES;

  localparam rsc_pkg::rsc_regs_s RESET_VAL = '{
    state:    rsc_pkg::ST_RUN,
    cause:    rsc_pkg::CAUSE_NONE,
    pin_key:  `RSC_PIN_KEY_PORT,
    lv_key:   `RSC_LV_KEY_ON,
    por_init: 1'b1,
    default:  '0
  };

  // ------------------------------------------------------------
  // helper functions
  // ------------------------------------------------------------
  // a keyed register is good only when it holds one of its two keys
  function automatic logic key_ok(input logic [7:0] key,
                                  input logic [7:0] key_a,
                                  input logic [7:0] key_b);
    key_ok = (key == key_a) || (key == key_b);
  endfunction

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == `RSC_ADDR_PIN_SEL) || (a == `RSC_ADDR_FLAGS) ||
                  (a == `RSC_ADDR_LV_SEL) || (a == `RSC_ADDR_STATUS);
  endfunction

  function automatic logic [31:0] read_word(input rsc_pkg::rsc_regs_s s,
                                            input logic [11:0]        a);
    read_word = 32'h0000_0000;
    unique case (a)
      `RSC_ADDR_PIN_SEL: read_word[7:0] = s.pin_key;
      `RSC_ADDR_LV_SEL:  read_word[7:0] = s.lv_key;
      `RSC_ADDR_FLAGS: begin
        read_word[`RSC_FLAG_IDLE_KEEP] = s.idle_keep;
        read_word[`RSC_FLAG_PIN]       = s.pin_flag;
        read_word[`RSC_FLAG_LOWSUP]    = s.lowsup_flag;
        read_word[`RSC_FLAG_LVERR]     = s.lverr_flag;
        read_word[`RSC_FLAG_WDERR]     = s.wderr_flag; // bits 6..4 stay zero
      end
      `RSC_ADDR_STATUS: begin
        read_word[`RSC_STAT_TIMEOUT] = s.timeout_flag;
        read_word[`RSC_STAT_PWRDOWN] = s.power_down_flag;
        read_word[`RSC_STAT_CHIPRST] = s.chip_reset;
        read_word[6:4]               = s.cause;
      end
      default: read_word = 32'h0000_0000;
    endcase
  endfunction

  // effects applied on the edge the chip reset starts
  function automatic rsc_pkg::rsc_regs_s enter_reset(input rsc_pkg::rsc_regs_s s,
                                                     input rsc_pkg::rsc_cause_e c);
    enter_reset            = s;
    enter_reset.state      = rsc_pkg::ST_RESET;
    enter_reset.cause      = c;
    enter_reset.hold_cnt   = 4'h0;
    enter_reset.chip_reset = 1'b1;
    enter_reset.pin_key    = `RSC_PIN_KEY_PORT;
    if (c != rsc_pkg::CAUSE_LOW_SUPPLY) begin
      enter_reset.lv_key = `RSC_LV_KEY_ON;
    end
    if (c == rsc_pkg::CAUSE_PIN_KEY) begin
      enter_reset.pin_flag = 1'b1;
    end
    if (c == rsc_pkg::CAUSE_LOW_SUPPLY) begin
      enter_reset.lowsup_flag = 1'b1;
    end
    if (c == rsc_pkg::CAUSE_WDT) begin
      enter_reset.timeout_flag = 1'b1;
    end
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  rsc_pkg::rsc_regs_s r;
  rsc_pkg::rsc_regs_s next_r;

  logic pin_bad;
  logic lv_bad;
  logic ext_low;
  logic lv_active;
  logic lv_qualified;
  logic wr_en;
  logic rd_setup;

  // key decode and low supply qualification terms
  assign pin_bad   = !key_ok(r.pin_key, `RSC_PIN_KEY_PORT, `RSC_PIN_KEY_RESET);
  assign lv_bad    = !key_ok(r.lv_key, `RSC_LV_KEY_ON, `RSC_LV_KEY_OFF);
  assign ext_low   = (r.pin_key == `RSC_PIN_KEY_RESET) && !shared_pin_in;
  assign lv_active = (r.lv_key == `RSC_LV_KEY_ON) && !sleep_idle_mode
                     && (r.state == rsc_pkg::ST_RUN);
  assign lv_qualified = lv_active && low_supply_detect && (r.qual_cnt >= QUAL_LIM);
  assign wr_en     = psel && penable && pwrite && addr_mapped(paddr)
                     && (r.state != rsc_pkg::ST_RESET);
  assign rd_setup  = psel && !penable && !pwrite;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_r             = r;
    next_r.slow_tick   = 1'b0;
    next_r.pc_sp_clear = 1'b0;
    next_r.por_init    = 1'b0;

    // slow oscillator tick divider
    if (r.tick_cnt == TICK_LAST) begin
      next_r.tick_cnt  = 12'h000;
      next_r.slow_tick = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 12'h001;
    end

    // register writes; flags other than idle keep can only be cleared by software
    if (wr_en) begin
      unique case (paddr)
        `RSC_ADDR_PIN_SEL: next_r.pin_key = pwdata[7:0];
        `RSC_ADDR_LV_SEL:  next_r.lv_key  = pwdata[7:0];
        `RSC_ADDR_FLAGS: begin
          next_r.idle_keep   = pwdata[`RSC_FLAG_IDLE_KEEP];
          next_r.pin_flag    = r.pin_flag & pwdata[`RSC_FLAG_PIN];
          next_r.lowsup_flag = r.lowsup_flag & pwdata[`RSC_FLAG_LOWSUP];
          next_r.lverr_flag  = r.lverr_flag & pwdata[`RSC_FLAG_LVERR];
          next_r.wderr_flag  = r.wderr_flag & pwdata[`RSC_FLAG_WDERR];
        end
        default: next_r.pin_key = r.pin_key;
      endcase
    end

    // read data captured in the setup phase
    if (rd_setup) begin
      next_r.prdata = addr_mapped(paddr) ? read_word(r, paddr) : 32'h0000_0000;
    end

    // hardware sets after the software clear, so a set wins
    if (lv_bad) begin
      next_r.lverr_flag = 1'b1;
    end
    if (watchdog_key_error) begin
      next_r.wderr_flag = 1'b1;
    end

    // power-down and timeout flags from core events
    if (watchdog_clear) begin
      next_r.timeout_flag    = 1'b0;
      next_r.power_down_flag = 1'b0;
    end
    if (halt_enter) begin
      next_r.power_down_flag = 1'b1;
    end

    // low supply must persist beyond the qualify time
    if (lv_active && low_supply_detect) begin
      if (r.qual_cnt != 16'hffff) begin
        next_r.qual_cnt = r.qual_cnt + 16'h0001;
      end
    end else begin
      next_r.qual_cnt = 16'h0000;
    end

    // warm timeout in sleep or idle: only pc and sp cleared
    if (watchdog_timeout && sleep_idle_mode && (r.state == rsc_pkg::ST_RUN)) begin
      next_r.pc_sp_clear     = 1'b1;
      next_r.timeout_flag    = 1'b1;
      next_r.power_down_flag = 1'b1;
    end

    // reset sequencer
    unique case (r.state)
      rsc_pkg::ST_RUN: begin
        if (ext_low) begin
          next_r = enter_reset(next_r, rsc_pkg::CAUSE_EXT_PIN);
        end else if (pin_bad) begin
          next_r.state   = rsc_pkg::ST_DEBOUNCE;
          next_r.cause   = rsc_pkg::CAUSE_PIN_KEY;
          next_r.deb_cnt = 2'h0;
        end else if (lv_bad) begin
          next_r.state   = rsc_pkg::ST_DEBOUNCE;
          next_r.cause   = rsc_pkg::CAUSE_LV_KEY;
          next_r.deb_cnt = 2'h0;
        end else if (watchdog_key_error) begin
          next_r.state   = rsc_pkg::ST_DEBOUNCE;
          next_r.cause   = rsc_pkg::CAUSE_WDT_KEY;
          next_r.deb_cnt = 2'h0;
        end else if (watchdog_timeout && !sleep_idle_mode) begin
          next_r.state   = rsc_pkg::ST_DEBOUNCE;
          next_r.cause   = rsc_pkg::CAUSE_WDT;
          next_r.deb_cnt = 2'h0;
        end else if (lv_qualified) begin
          next_r.state   = rsc_pkg::ST_DEBOUNCE;
          next_r.cause   = rsc_pkg::CAUSE_LOW_SUPPLY;
          next_r.deb_cnt = 2'h0;
        end
      end
      rsc_pkg::ST_DEBOUNCE: begin
        // reset lands on the second slow tick, before the third
        if (r.slow_tick) begin
          if (r.deb_cnt == DEB_LAST) begin
            next_r = enter_reset(next_r, r.cause);
          end else begin
            next_r.deb_cnt = r.deb_cnt + 2'h1;
          end
        end
      end
      rsc_pkg::ST_RESET: begin
        // hold chip reset for a fixed eight cycles; the pin key is back at port, so a low pin does not extend it
        if (r.hold_cnt != HOLD_LAST) begin
          next_r.hold_cnt = r.hold_cnt + 4'h1;
        end else if (!ext_low) begin
          next_r.state      = rsc_pkg::ST_RUN;
          next_r.chip_reset = 1'b0;
        end
      end
      default: next_r = RESET_VAL;
    endcase
  end

  // ------------------------------------------------------------
  // state register; power-on values come from the async reset
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= RESET_VAL;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign prdata                 = r.prdata;
  assign pready                 = 1'b1;
  assign pslverr                = psel && penable && !addr_mapped(paddr);
  assign chip_reset             = r.chip_reset;
  assign pc_sp_clear            = r.pc_sp_clear;
  assign por_init               = r.por_init;
  assign pin_is_reset_input     = (r.pin_key == `RSC_PIN_KEY_RESET);
  assign low_voltage_monitor_on = lv_active;
  assign idle_system_clock_keep = r.idle_keep;
  assign timeout_flag           = r.timeout_flag;
  assign power_down_flag        = r.power_down_flag;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // cycles spent waiting in debounce
  int unsigned deb_wait;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      deb_wait <= 0;
    end else if (r.state == rsc_pkg::ST_DEBOUNCE) begin
      deb_wait <= deb_wait + 1;
    end else begin
      deb_wait <= 0;
    end
  end

  sequence s_reset_start;
    $rose(r.chip_reset);
  endsequence

  sequence s_from_debounce;
    $past(r.state) == rsc_pkg::ST_DEBOUNCE;
  endsequence

  a_deb_bound: assert property (
    deb_wait <= DEB_MAX)
    else $error("debounce wait exceeded three slow ticks");

  a_deb_two_ticks: assert property (
    s_reset_start and s_from_debounce |-> deb_wait > `RSC_SLOW_OSC_CYCLES)
    else $error("keyed reset asserted before second slow tick");

  a_pin_key_restore: assert property (
    s_reset_start |-> r.pin_key == `RSC_PIN_KEY_PORT)
    else $error("pin select key not restored on reset");

  a_pin_flag_cause: assert property (
    $rose(r.pin_flag) |-> $rose(r.chip_reset) && r.cause == rsc_pkg::CAUSE_PIN_KEY)
    else $error("pin select flag rose without pin key reset");

  a_flags_hi_zero: assert property (
    rd_setup && paddr == `RSC_ADDR_FLAGS |=> prdata[6:4] == 3'b000)
    else $error("unimplemented flag bits read nonzero");

  a_lowsup_keep_key: assert property (
    s_reset_start and r.cause == rsc_pkg::CAUSE_LOW_SUPPLY
      |-> r.lv_key == $past(r.lv_key) && r.lowsup_flag)
    else $error("low supply reset changed select key or missed flag");

  a_lv_key_restore: assert property (
    s_reset_start and r.cause == rsc_pkg::CAUSE_LV_KEY |-> r.lv_key == `RSC_LV_KEY_ON)
    else $error("bad select key not restored on reset");

  a_lverr_sets: assert property (
    lv_bad |=> r.lverr_flag)
    else $error("select error flag not set for bad key");

  a_sleep_no_lv: assert property (
    sleep_idle_mode |-> !lv_active ##1 r.qual_cnt == 16'h0000)
    else $error("low supply watch active in sleep");

  a_short_low_ignored: assert property (
    r.state == rsc_pkg::ST_RUN && r.qual_cnt < QUAL_LIM && !pin_bad && !lv_bad
      && !ext_low && !watchdog_key_error && !watchdog_timeout
      |=> r.state == rsc_pkg::ST_RUN)
    else $error("short low supply started a reset");

  a_wdt_warm: assert property (
    watchdog_timeout && sleep_idle_mode && r.state == rsc_pkg::ST_RUN
      |=> pc_sp_clear && timeout_flag && power_down_flag && !chip_reset)
    else $error("sleep timeout did not perform warm reset");

  a_wdt_normal: assert property (
    s_reset_start and r.cause == rsc_pkg::CAUSE_WDT |-> r.timeout_flag)
    else $error("normal timeout reset missed timeout flag");

  a_ext_pin_reset: assert property (
    r.state == rsc_pkg::ST_RUN && ext_low |=> chip_reset)
    else $error("low reset input did not reset chip");

  a_por_init_flags: assert property (
    por_init |-> !timeout_flag && !power_down_flag && !chip_reset)
    else $error("power-on state not clean");

endmodule

//--- test/rsc_supply_pin_model.sv
`timescale 1ns/1ps

// ------------------------------------------------------------
// far side: reset pin and supply monitor
// ------------------------------------------------------------
module rsc_supply_pin_model (
  input  wire logic        pclk,
  input  wire logic        pin_low_cmd,
  input  wire logic        sup_go,
  input  wire logic [15:0] sup_len,
  output logic             shared_pin_in,
  output logic             low_supply_detect
);
  logic [15:0] sup_cnt = 16'h0000;

  // pin has a pull-up, so it idles high when nobody pulls it
  assign shared_pin_in = ~pin_low_cmd;

  // supply stays in the low band for exactly sup_len cycles
  always_ff @(posedge pclk) begin
    if (sup_go) begin
      sup_cnt <= sup_len;
    end else if (sup_cnt != 16'h0000) begin
      sup_cnt <= sup_cnt - 16'h0001;
    end
  end

  // monitor output follows the low-band span
  assign low_supply_detect = (sup_cnt != 16'h0000);
endmodule

//--- test/rsc_reset_ctrl_tb.sv
`timescale 1ns/1ps
`include "rsc_map.svh"

module rsc_reset_ctrl_tb;
  localparam int LVQ  = 5;
  localparam int TICK = `RSC_SLOW_OSC_CYCLES;

  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pin_low, sup_go, sleep, wdt, wdkey;
  logic        halt, wclr, pready, pslverr, chip_reset, pc_sp_clear, por_init;
  logic        pin_rst, mon_on, idle_keep, to_flag, pd_flag, pin_in, sup_det, rerr;
  logic [11:0] paddr;
  logic [15:0] sup_len;
  logic [31:0] pwdata, prdata, rdata;
  int          seed = 61746;
  int          err_count = 0;
  int          checks_done = 0;
  bit          saw;

  // ------------------------------------------------------------
  // clock, design and far side
  // ------------------------------------------------------------
  always #5 pclk = ~pclk;

  rsc_reset_ctrl #(.LV_QUAL_CYCLES(LVQ)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .shared_pin_in(pin_in), .low_supply_detect(sup_det), .sleep_idle_mode(sleep),
    .watchdog_timeout(wdt), .watchdog_key_error(wdkey), .halt_enter(halt),
    .watchdog_clear(wclr), .chip_reset(chip_reset), .pc_sp_clear(pc_sp_clear),
    .por_init(por_init), .pin_is_reset_input(pin_rst), .low_voltage_monitor_on(mon_on),
    .idle_system_clock_keep(idle_keep), .timeout_flag(to_flag),
    .power_down_flag(pd_flag));

  rsc_supply_pin_model far (
    .pclk(pclk), .pin_low_cmd(pin_low), .sup_go(sup_go), .sup_len(sup_len),
    .shared_pin_in(pin_in), .low_supply_detect(sup_det));

  // ------------------------------------------------------------
  // compare, bus and wait helpers
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, pready}, 32'h0000_0001, "pready wait");
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // write a byte with random upper bits, which the design ignores
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    logic [31:0] r;
    r = $random(seed);
    apb(1'b1, a, {r[31:8], v});
    // let the write settle before any output is looked at
    @(posedge pclk);
  endtask

  task automatic rd(input logic [11:0] a, input logic [7:0] v, input string what);
    apb(1'b0, a, 32'h0000_0000);
    check(rdata, {24'h00_0000, v}, what);
  endtask

  // chip reset must rise within lo..hi cycles, then release
  task automatic wait_rst(input int lo, input int hi, input string what);
    int n;
    n = 0;
    while (chip_reset !== 1'b1 && n <= hi) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, (n >= lo && n <= hi)}, 32'h0000_0001, what);
    n = 0;
    while (chip_reset === 1'b1 && n < 100) begin
      @(posedge pclk);
      n++;
    end
    check({31'h0, chip_reset}, 32'h0000_0000, what);
    $display("test %s done", what);
  endtask

  // no chip reset over a whole debounce span
  task automatic no_rst(input string what);
    saw = 1'b0;
    repeat (2 * TICK + 150) begin
      @(posedge pclk);
      if (chip_reset === 1'b1) saw = 1'b1;
    end
    check({31'h0, saw}, 32'h0000_0000, what);
    $display("test %s done", what);
  endtask

  // keys back at power-on value, flags as expected, then cleared
  task automatic after_rst(input logic [7:0] fl);
    rd(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_PORT, "pin key");
    rd(`RSC_ADDR_LV_SEL, `RSC_LV_KEY_ON, "lv key");
    rd(`RSC_ADDR_FLAGS, fl, "flags");
    wr(`RSC_ADDR_FLAGS, 8'h00);
  endtask

  // undefined key value drawn at random
  function automatic logic [7:0] bad_key(input logic [7:0] k1, input logic [7:0] k2);
    logic [7:0] v;
    do v = $random(seed); while (v == k1 || v == k2);
    return v;
  endfunction

  // pulse one event input for a single cycle
  task automatic pulse(input int k);
    @(posedge pclk);
    case (k)
      0: wdt <= 1'b1;
      1: wdkey <= 1'b1;
      2: halt <= 1'b1;
      default: wclr <= 1'b1;
    endcase
    @(posedge pclk);
    {wdt, wdkey, halt, wclr} <= 4'h0;
  endtask

  task automatic supply(input logic [15:0] len);
    @(posedge pclk);
    sup_len <= len;
    sup_go <= 1'b1;
    @(posedge pclk);
    sup_go <= 1'b0;
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, pin_low, sup_go, sleep} = 7'h00;
    {wdt, wdkey, halt, wclr} = 4'h0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    sup_len = 16'h0000;
    repeat (12) @(posedge pclk);
    check({31'h0, por_init}, 32'h0000_0001, "por init held");
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    check({31'h0, por_init}, 32'h0000_0000, "por init released");
    rd(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_PORT, "pin key por");
    rd(`RSC_ADDR_LV_SEL, `RSC_LV_KEY_ON, "lv key por");
    rd(`RSC_ADDR_FLAGS, 8'h00, "flags por");
    rd(`RSC_ADDR_STATUS, 8'h00, "status por");
    apb(1'b0, 12'h010, 32'h0000_0000);
    check({31'h0, rerr}, 32'h0000_0001, "unmapped error");
    wr(`RSC_ADDR_FLAGS, 8'hf8);
    rd(`RSC_ADDR_FLAGS, 8'h80, "flag write");
    check({31'h0, idle_keep}, 32'h0000_0001, "idle keep");
    wr(`RSC_ADDR_FLAGS, 8'h00);
    wr(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_RESET);
    check({31'h0, pin_rst}, 32'h0000_0001, "pin as reset");
    pulse(2);
    pin_low <= 1'b1;
    wait_rst(0, 3, "external pin");
    pin_low <= 1'b0;
    after_rst(8'h00);
    check({30'h0, to_flag, pd_flag}, 32'h0000_0001, "flags kept");
    check({31'h0, pin_rst}, 32'h0000_0000, "pin as port");
    for (int i = 0; i < 2; i++) begin
      wr(`RSC_ADDR_PIN_SEL, (i == 0) ? 8'h00 : bad_key(8'h55, 8'haa));
      wait_rst(TICK, 3 * TICK, "bad pin key");
      after_rst(8'h01 << `RSC_FLAG_PIN);
      wr(`RSC_ADDR_LV_SEL, (i == 0) ? 8'hff : bad_key(8'h5a, 8'ha5));
      wait_rst(TICK, 3 * TICK, "bad lv key");
      after_rst(8'h01 << `RSC_FLAG_LVERR);
    end
    supply(LVQ);
    no_rst("short low supply");
    sleep <= 1'b1;
    supply(40);
    check({31'h0, mon_on}, 32'h0000_0000, "monitor in sleep");
    no_rst("sleep low supply");
    sleep <= 1'b0;
    wr(`RSC_ADDR_LV_SEL, `RSC_LV_KEY_OFF);
    check({31'h0, mon_on}, 32'h0000_0000, "monitor off key");
    supply(40);
    no_rst("lv disabled");
    wr(`RSC_ADDR_LV_SEL, `RSC_LV_KEY_ON);
    check({31'h0, mon_on}, 32'h0000_0001, "monitor on key");
    wr(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_RESET);
    supply(40);
    wait_rst(TICK, 3 * TICK + LVQ + 50, "low supply");
    after_rst(8'h01 << `RSC_FLAG_LOWSUP);
    check({30'h0, to_flag, pd_flag}, 32'h0000_0001, "lv keeps flags");
    pulse(2);
    pulse(0);
    wait_rst(TICK, 3 * TICK, "watchdog normal");
    check({30'h0, to_flag, pd_flag}, 32'h0000_0003, "to set pd kept");
    after_rst(8'h00);
    pulse(3);
    @(posedge pclk);
    check({30'h0, to_flag, pd_flag}, 32'h0000_0000, "watchdog clear");
    wr(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_RESET);
    sleep <= 1'b1;
    pulse(0);
    saw = 1'b0;
    repeat (4) begin
      @(posedge pclk);
      if (pc_sp_clear === 1'b1) saw = 1'b1;
    end
    check({31'h0, saw}, 32'h0000_0001, "pc sp clear");
    check({30'h0, to_flag, pd_flag}, 32'h0000_0003, "sleep timeout flags");
    sleep <= 1'b0;
    no_rst("sleep timeout");
    rd(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_RESET, "warm keeps key");
    wr(`RSC_ADDR_PIN_SEL, `RSC_PIN_KEY_PORT);
    pulse(3);
    pulse(1);
    wait_rst(TICK, 3 * TICK, "watchdog key");
    after_rst(8'h01 << `RSC_FLAG_WDERR);
    finish_test;
  end

  // ------------------------------------------------------------
  // hang guard, well beyond the expected run length
  // ------------------------------------------------------------
  initial begin
    #950_000;
    err_count++;
    $display("wrong value at %0t: run timed out", $time);
    finish_test;
  end
endmodule
